// *** core/flk_pkg.sv ***
// package: lock level types, security byte layout, constants
package flk_pkg;

  // four protection levels, lowest first
  typedef enum logic [1:0] {
    LVL_1,
    LVL_2,
    LVL_3,
    LVL_4
  } flk_level_e;

  // parallel programmer commands
  typedef enum logic [2:0] {
    PCMD_READ_ID,
    PCMD_PROG_CODE,
    PCMD_VERIFY_CODE,
    PCMD_PROG_HSB,
    PCMD_READ_HSB,
    PCMD_CHIP_ERASE,
    PCMD_PROG_XAF,
    PCMD_READ_XAF
  } flk_pcmd_e;

  // parallel programmer request and answer
  typedef struct packed {
    flk_pcmd_e   cmd;
    logic [15:0] addr;
    logic [7:0]  data;
  } flk_preq_s;

  typedef struct packed {
    logic [7:0] data;
    logic       refused;
  } flk_presp_s;

  // in-system / firmware call request
  typedef struct packed {
    logic        write;
    logic        extra_array_flash;
    logic [15:0] addr;
    logic [7:0]  data;
  } flk_swreq_s;

  // hardware security byte bit positions
  localparam int unsigned HSB_X2_BIT   = 7;
  localparam int unsigned HSB_BOOT_JUMP_SELECT_BIT = 6;
  localparam int unsigned HSB_AUX_RAM_ENABLE_BIT = 3;
  localparam int unsigned HSB_LB2_BIT  = 2;
  localparam int unsigned HSB_LB1_BIT  = 1;
  localparam int unsigned HSB_LB0_BIT  = 0;

  // byte values: factory default, erased, reserved bits
  localparam logic [7:0] HSB_FACTORY   = 8'hbb;
  localparam logic [7:0] HSB_ERASED    = 8'hff;
  localparam logic [7:0] HSB_RSVD_MASK = 8'h30;

  // extra array flash: depth, index width, register slots
  localparam int unsigned XAF_DEPTH   = 16;
  localparam int unsigned XAF_AW      = 4;
  localparam logic [3:0]  XAF_SBV_IDX = 4'h0;
  localparam logic [3:0]  XAF_SSB_IDX = 4'h1;
  localparam logic [3:0]  XAF_BSB_IDX = 4'h2;
  localparam logic [7:0]  SBV_RESET   = 8'hfc;
  localparam logic [7:0]  SSB_RESET   = 8'hff;
  localparam logic [7:0]  BSB_RESET   = 8'h00;
  localparam logic [7:0]  XAF_BLANK   = 8'hff;

  // boot addresses chosen by the boot-jump bit
  localparam logic [15:0] BOOT_ADDR_ISP  = 16'hf800;
  localparam logic [15:0] BOOT_ADDR_USER = 16'h0000;

  // part identification bytes; values are arbitrary
  localparam logic [7:0] PART_ID_0 = 8'h5a;
  localparam logic [7:0] PART_ID_1 = 8'h3c;

  // chip erase duration, rounded up to whole cycles
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ERASE_TIME_NS = 400;
  localparam int unsigned ERASE_CYCLES  =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CW      = 6;

  // lock bits to level: highest programmed (zero) bit wins
  function automatic flk_level_e lock_to_level(input logic [2:0] lb);
    flk_level_e lv;
    lv = LVL_1;
    if (!lb[2]) begin
      lv = LVL_4;
    end else if (!lb[1]) begin
      lv = LVL_3;
    end else if (!lb[0]) begin
      lv = LVL_2;
    end
    return lv;
  endfunction

endpackage

// *** core/flk_level_decode.sv ***
// lock bits to protection level and the gates each level closes
`timescale 1ns/1ps
module flk_level_decode import flk_pkg::*; (
  // lock bits as stored, one means unprogrammed
  input  wire logic [2:0] lockBits,
  // decoded level and gates
  output flk_level_e      level,
  output logic            blockTblRead,
  output logic            holdEa,
  output logic            blockProg,
  output logic            blockVerify,
  output logic            blockExtExec
);

  // each level adds to the ones below it
  always_comb begin
    level        = lock_to_level(lockBits); // R2 R3
    blockTblRead = (level != LVL_1); // R1 R4
    holdEa       = (level != LVL_1); // R5
    blockProg    = (level != LVL_1); // R6
    blockVerify  = (level == LVL_3) || (level == LVL_4); // R8
    blockExtExec = (level == LVL_4); // R9
  end

endmodule

// *** core/flk_ea_latch.sv ***
// external-access pin: captured once after reset, held when locked
`timescale 1ns/1ps
module flk_ea_latch (
  // clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // pin and lock control
  input  wire logic eaPin,
  input  wire logic holdEa,
  // effective level
  output logic      eaEffective
);

  logic captured_r;
  logic captured_nxt;
  logic eaHeld_r;
  logic eaHeld_nxt;

  // reset loads constants; the pin is caught at the first edge after release
  always_comb begin
    captured_nxt = 1'b1;
    eaHeld_nxt   = captured_r ? eaHeld_r : eaPin; // R5
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      captured_r <= 1'b0;
      eaHeld_r   <= 1'b0;
    end else begin
      captured_r <= captured_nxt;
      eaHeld_r   <= eaHeld_nxt;
    end
  end

  // before capture the pin passes straight through
  assign eaEffective = (holdEa && captured_r) ? eaHeld_r : eaPin; // R5

endmodule

// *** core/flk_lock_ctrl.sv ***
// flash lock controller: security byte, level gating, programmer ports
// Operation
// (R1) all lock bits unprogrammed gives level 1 with no restriction
// (R2) highest programmed lock bit sets level; none programmed means level 1
// (R3) lock bit reads one unprogrammed, zero programmed
// (R4) level 2 and up: external table reads cannot see internal code
// (R5) level 2 and up: access pin latched at reset, later changes ignored
// (R6) level 2 and up: parallel code programming refused
// (R7) level 2: in-system and firmware programming still allowed
// (R8) level 3 and up: parallel code verify refused
// (R9) level 4: external execution disabled; factory default level
// (R10) programmer sets levels 2 or 3 only after verifying code
// (R11) lock bits gate parallel port only; in-system path stays open
// (R12) programmer issues chip erase before loading new code
// (R13) chip erase clears flash and returns security byte to unprogrammed
// (R14) part identification readable at every level
// (R15) shipped with boot-jump bit programmed, starting in-system mode
// (R16) shipped with double-speed bit unprogrammed, standard speed
// (R17) shipped with extended RAM bit unprogrammed, RAM enabled
// (R18) shipped with lock bits at level four
// (R19) extra-array registers reachable by programmer, in-system and firmware
// (R20) boot address f800h when boot-jump zero, 0000h when one
`timescale 1ns/1ps
module flk_lock_ctrl import flk_pkg::*; (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // parallel programmer port
  input  wire logic       progValid,
  input  flk_preq_s       progReq,
  output logic            progReady,
  output logic            progRespValid,
  output flk_presp_s      progResp,
  // in-system and firmware call port
  input  wire logic       swValid,
  input  flk_swreq_s      swReq,
  output logic            swReady,
  output logic            swRespValid,
  output logic [7:0]      swRdata,
  // code flash array
  output logic            flashWrEn,
  output logic            flashEraseAll,
  output logic [15:0]     flashAddr,
  output logic [7:0]      flashWdata,
  input  wire logic [7:0] flashRdata,
  // core side gating
  input  wire logic       tblValid,
  input  wire logic       tblFromExt,
  output logic            tblAllow,
  output logic            extExecAllow,
  input  wire logic       eaPin,
  output logic            eaEffective,
  // configuration seen by the core
  output flk_level_e      secLevel,
  output logic [15:0]     bootAddr,
  output logic            doubleSpeed,
  output logic            auxRamEnable,
  output logic [7:0]      bootVectorHigh
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_ERASE
  } flk_state_e;

  // controller state
  flk_state_e           state_r;
  flk_state_e           state_nxt;
  logic [7:0]           hsb_r;
  logic [7:0]           hsb_nxt;
  logic [ERASE_CW-1:0]  eraseCnt_r;
  logic [ERASE_CW-1:0]  eraseCnt_nxt;
  logic                 readForProg_r;
  logic                 readForProg_nxt;
  // answer registers
  logic                 progRespValid_nxt;
  flk_presp_s           progResp_nxt;
  logic                 swRespValid_nxt;
  logic [7:0]           swRdata_nxt;
  // flash strobes
  logic                 flashWrEn_nxt;
  logic                 flashEraseAll_nxt;
  logic [15:0]          flashAddr_nxt;
  logic [7:0]           flashWdata_nxt;
  // extra array flash
  logic [7:0]           xaf_r [XAF_DEPTH];
  logic                 xafWr;
  logic [XAF_AW-1:0]    xafIdx;
  logic [7:0]           xafWdata;
  logic                 xafErase;
  // level gates
  logic                 blockTblRead;
  logic                 holdEa;
  logic                 blockProg;
  logic                 blockVerify;
  logic                 blockExtExec;
  logic                 progTake;
  logic                 swTake;

  // level decode of the three lock bits
  flk_level_decode u_decode (
    .lockBits     (hsb_r[HSB_LB2_BIT:HSB_LB0_BIT]),
    .level        (secLevel),
    .blockTblRead (blockTblRead),
    .holdEa       (holdEa),
    .blockProg    (blockProg),
    .blockVerify  (blockVerify),
    .blockExtExec (blockExtExec)
  );

  // external-access pin capture
  flk_ea_latch u_ea (
    .clock       (clock),
    .arst_n      (arst_n),
    .eaPin       (eaPin),
    .holdEa      (holdEa),
    .eaEffective (eaEffective)
  );

  // extra array reset contents
  function automatic logic [7:0] xaf_init(input int unsigned idx);
    logic [7:0] v;
    v = XAF_BLANK;
    if (idx == 32'(XAF_SBV_IDX)) begin
      v = SBV_RESET;
    end else if (idx == 32'(XAF_SSB_IDX)) begin
      v = SSB_RESET;
    end else if (idx == 32'(XAF_BSB_IDX)) begin
      v = BSB_RESET;
    end
    return v;
  endfunction

  // programmer has priority; the firmware port waits behind it
  assign progReady = (state_r == ST_IDLE);
  assign swReady   = (state_r == ST_IDLE) && !progValid;
  assign progTake  = progValid && progReady;
  assign swTake    = swValid && swReady;

  // core gating is combinational so a fetch sees the current level
  assign tblAllow     = !(tblValid && tblFromExt && blockTblRead); // R4
  assign extExecAllow = !blockExtExec; // R9

  // configuration bits straight from the security byte; boot vector high byte from the extra array
  assign doubleSpeed    = !hsb_r[HSB_X2_BIT]; // R16
  assign auxRamEnable   = hsb_r[HSB_AUX_RAM_ENABLE_BIT]; // R17
  assign bootAddr       = hsb_r[HSB_BOOT_JUMP_SELECT_BIT] ? BOOT_ADDR_USER
                                              : BOOT_ADDR_ISP; // R20
  assign bootVectorHigh = xaf_r[XAF_SBV_IDX];

  // command decode and sequencing
  always_comb begin
    state_nxt         = state_r;
    hsb_nxt           = hsb_r;
    eraseCnt_nxt      = eraseCnt_r;
    readForProg_nxt   = readForProg_r;
    progRespValid_nxt = 1'b0;
    progResp_nxt      = progResp;
    swRespValid_nxt   = 1'b0;
    swRdata_nxt       = swRdata;
    flashWrEn_nxt     = 1'b0;
    flashEraseAll_nxt = 1'b0;
    flashAddr_nxt     = flashAddr;
    flashWdata_nxt    = flashWdata;
    xafWr             = 1'b0;
    xafIdx            = progTake ? progReq.addr[XAF_AW-1:0]
                                 : swReq.addr[XAF_AW-1:0];
    xafWdata          = progTake ? progReq.data : swReq.data;
    xafErase          = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (progTake) begin
          progResp_nxt.refused = 1'b0;
          progResp_nxt.data    = 8'h00;
          progRespValid_nxt    = 1'b1;
          case (progReq.cmd)
            PCMD_READ_ID: begin
              progResp_nxt.data = progReq.addr[0] ? PART_ID_1 : PART_ID_0; // R14
            end
            PCMD_PROG_CODE: begin
              if (blockProg) begin
                progResp_nxt.refused = 1'b1; // R6
              end else begin
                flashWrEn_nxt  = 1'b1;
                flashAddr_nxt  = progReq.addr;
                flashWdata_nxt = progReq.data;
              end
            end
            PCMD_VERIFY_CODE: begin
              if (blockVerify) begin
                progResp_nxt.refused = 1'b1; // R8
              end else begin
                flashAddr_nxt     = progReq.addr;
                readForProg_nxt   = 1'b1;
                progRespValid_nxt = 1'b0;
                state_nxt         = ST_READ;
              end
            end
            PCMD_PROG_HSB: begin
              // programming only drives bits to zero; reserved bits stay one
              hsb_nxt = hsb_r & (progReq.data | HSB_RSVD_MASK); // R3 R11
            end
            PCMD_READ_HSB: begin
              progResp_nxt.data = hsb_r;
            end
            PCMD_CHIP_ERASE: begin
              flashEraseAll_nxt = 1'b1;
              eraseCnt_nxt      = ERASE_CW'(ERASE_CYCLES - 1);
              progRespValid_nxt = 1'b0;
              state_nxt         = ST_ERASE; // R13
            end
            PCMD_PROG_XAF: begin
              xafWr = 1'b1; // R19
            end
            PCMD_READ_XAF: begin
              progResp_nxt.data = xaf_r[xafIdx]; // R19
            end
            default: begin
              progResp_nxt.refused = 1'b1;
            end
          endcase
        end else if (swTake) begin
          // in-system path ignores the lock bits entirely
          swRespValid_nxt = 1'b1; // R7 R11
          swRdata_nxt     = 8'h00;
          if (swReq.extra_array_flash) begin
            if (swReq.write) begin
              xafWr = 1'b1; // R19
            end else begin
              swRdata_nxt = xaf_r[xafIdx]; // R19
            end
          end else if (swReq.write) begin
            flashWrEn_nxt  = 1'b1; // R7
            flashAddr_nxt  = swReq.addr;
            flashWdata_nxt = swReq.data;
          end else begin
            flashAddr_nxt   = swReq.addr;
            readForProg_nxt = 1'b0;
            swRespValid_nxt = 1'b0;
            state_nxt       = ST_READ;
          end
        end
      end
      ST_READ: begin
        // flash data is valid one cycle after the address
        if (readForProg_r) begin
          progRespValid_nxt    = 1'b1;
          progResp_nxt.data    = flashRdata;
          progResp_nxt.refused = 1'b0;
        end else begin
          swRespValid_nxt = 1'b1;
          swRdata_nxt     = flashRdata;
        end
        state_nxt = ST_IDLE;
      end
      ST_ERASE: begin
        flashEraseAll_nxt = 1'b1;
        if (eraseCnt_r == '0) begin
          flashEraseAll_nxt    = 1'b0;
          hsb_nxt              = HSB_ERASED; // R13 R1
          xafErase             = 1'b1;
          progRespValid_nxt    = 1'b1;
          progResp_nxt.refused = 1'b0;
          progResp_nxt.data    = 8'h00;
          state_nxt            = ST_IDLE;
        end else begin
          eraseCnt_nxt = eraseCnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state and answer registers
  // security byte powers up at the shipped value: nonvolatile store is
  // modelled by reset, so a reset after programming restores the default
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r       <= ST_IDLE;
      hsb_r         <= HSB_FACTORY; // R15 R16 R17 R18 R9
      eraseCnt_r    <= '0;
      readForProg_r <= 1'b0;
      progRespValid <= 1'b0;
      progResp      <= '0;
      swRespValid   <= 1'b0;
      swRdata       <= 8'h00;
      flashWrEn     <= 1'b0;
      flashEraseAll <= 1'b0;
      flashAddr     <= 16'h0000;
      flashWdata    <= 8'h00;
    end else begin
      state_r       <= state_nxt;
      hsb_r         <= hsb_nxt;
      eraseCnt_r    <= eraseCnt_nxt;
      readForProg_r <= readForProg_nxt;
      progRespValid <= progRespValid_nxt;
      progResp      <= progResp_nxt;
      swRespValid   <= swRespValid_nxt;
      swRdata       <= swRdata_nxt;
      flashWrEn     <= flashWrEn_nxt;
      flashEraseAll <= flashEraseAll_nxt;
      flashAddr     <= flashAddr_nxt;
      flashWdata    <= flashWdata_nxt;
    end
  end

  // extra array: chip erase leaves its software registers untouched
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int unsigned i = 0; i < XAF_DEPTH; i++) begin
        xaf_r[i] <= xaf_init(i);
      end
    end else if (xafWr && !xafErase) begin
      xaf_r[xafIdx] <= xafWdata;
    end
  end

endmodule

// *** dv/flk_flash_model.sv ***
// code flash array model: combinational read, byte write, whole-array erase
`timescale 1ns/1ps
module flk_flash_model (
  // clock
  input  wire logic        clock,
  // array port from the controller
  input  wire logic        flashWrEn,
  input  wire logic        flashEraseAll,
  input  wire logic [15:0] flashAddr,
  input  wire logic [7:0]  flashWdata,
  output logic [7:0]       flashRdata
);
  // only the low address byte is kept, enough for the bench
  logic [7:0] mem [256];

  // non-blank start so an untouched byte other than a5h never looks erased
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // read is combinational behind the controller's registered address, so
  // the byte stands in the cycle after the address is set
  assign flashRdata = mem[flashAddr[7:0]];

  // writes and erase land on the clock edge
  always @(posedge clock) begin
    if (flashEraseAll) begin
      foreach (mem[i]) begin
        mem[i] <= 8'hff;
      end
    end else if (flashWrEn) begin
      mem[flashAddr[7:0]] <= flashWdata;
    end
  end
endmodule

// *** dv/flk_lock_ctrl_asserts.sv ***
// checker: level gating and programmer port answers of the lock controller
`timescale 1ns/1ps
module flk_lock_ctrl_asserts import flk_pkg::*; (
  // clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // programmer port
  input  wire logic progValid,
  input  flk_preq_s progReq,
  input  wire logic progReady,
  input  wire logic progRespValid,
  input  flk_presp_s progResp,
  // software port
  input  wire logic swValid,
  input  wire logic swReady,
  input  wire logic swRespValid,
  // flash and core gating
  input  wire logic flashEraseAll,
  input  wire logic tblValid,
  input  wire logic tblFromExt,
  input  wire logic tblAllow,
  input  wire logic extExecAllow,
  input  wire logic eaEffective,
  input  flk_level_e secLevel
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic       progTake;
  logic       swTake;
  logic [1:0] upCnt_r;
  logic [1:0] upCnt_nxt;

  // edges since reset, so the pin capture has surely happened
  always_comb begin
    progTake = progValid && progReady;
    swTake = swValid && swReady;
    upCnt_nxt = (upCnt_r == 2'h3) ? upCnt_r : upCnt_r + 2'h1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      upCnt_r <= 2'h0;
    end else begin
      upCnt_r <= upCnt_nxt;
    end
  end

  level_open_a: assert property (secLevel == LVL_1 |-> tblAllow && extExecAllow)
    else $error("level 1 gated a core access");
  tbl_block_a: assert property (tblValid && tblFromExt && secLevel != LVL_1 |-> !tblAllow)
    else $error("external table read reached internal code");
  ext_exec_a: assert property (extExecAllow == (secLevel != LVL_4))
    else $error("external execution gate wrong for level");
  ea_hold_a: assert property (upCnt_r == 2'h3 && secLevel != LVL_1 &&
    $past(secLevel) != LVL_1 |-> $stable(eaEffective)) else $error("access pin not held");
  prog_refuse_a: assert property (progTake && progReq.cmd == PCMD_PROG_CODE &&
    secLevel != LVL_1 |=> progRespValid && progResp.refused) else $error("code program taken");
  verify_refuse_a: assert property (progTake && progReq.cmd == PCMD_VERIFY_CODE &&
    secLevel inside {LVL_3, LVL_4} |-> ##[1:2] (progRespValid && progResp.refused))
    else $error("code verify not refused");
  id_open_a: assert property (progTake && progReq.cmd == PCMD_READ_ID |=>
    progRespValid && !progResp.refused) else $error("part id refused");
  erase_run_a: assert property (progTake && progReq.cmd == PCMD_CHIP_ERASE |=>
    flashEraseAll [*8] ##8 flashEraseAll ##1 (!flashEraseAll && progRespValid &&
    secLevel == LVL_1)) else $error("chip erase length or result wrong");
  sw_answer_a: assert property (swTake |-> ##[1:2] swRespValid)
    else $error("software request not answered");

  erase_c: cover property (progTake && progReq.cmd == PCMD_CHIP_ERASE);
  refuse_c: cover property (progRespValid && progResp.refused);
  sw_locked_c: cover property (swTake && secLevel == LVL_4);
endmodule

// *** dv/tb_flk_lock_ctrl.sv ***
// testbench: lock levels, programmer and software ports of the lock controller
`timescale 1ns/1ps
module tb_flk_lock_ctrl import flk_pkg::*;;
  logic       clock, arst_n, progValid, progReady, progRespValid, swValid, swReady;
  logic       swRespValid, flashWrEn, flashEraseAll, tblValid, tblFromExt, tblAllow;
  logic       extExecAllow, eaPin, eaEffective, doubleSpeed, auxRamEnable;
  logic [7:0] swRdata, flashWdata, flashRdata, bootVectorHigh, swData;
  logic [15:0] flashAddr, bootAddr;
  flk_preq_s  progReq;
  flk_presp_s progResp, rsp;
  flk_swreq_s swReq;
  flk_level_e secLevel;
  int         nFail = 0;
  int         totalChecks = 0;
  int         cycles = 0;

  flk_lock_ctrl u_flk_lock_ctrl (.clock(clock), .arst_n(arst_n), .progValid(progValid),
    .progReq(progReq), .progReady(progReady), .progRespValid(progRespValid),
    .progResp(progResp), .swValid(swValid), .swReq(swReq), .swReady(swReady),
    .swRespValid(swRespValid), .swRdata(swRdata), .flashWrEn(flashWrEn),
    .flashEraseAll(flashEraseAll), .flashAddr(flashAddr), .flashWdata(flashWdata),
    .flashRdata(flashRdata), .tblValid(tblValid), .tblFromExt(tblFromExt),
    .tblAllow(tblAllow), .extExecAllow(extExecAllow), .eaPin(eaPin),
    .eaEffective(eaEffective), .secLevel(secLevel), .bootAddr(bootAddr),
    .doubleSpeed(doubleSpeed), .auxRamEnable(auxRamEnable), .bootVectorHigh(bootVectorHigh));

  flk_flash_model u_flk_flash_model (.clock(clock), .flashWrEn(flashWrEn),
    .flashEraseAll(flashEraseAll), .flashAddr(flashAddr), .flashWdata(flashWdata),
    .flashRdata(flashRdata));

  task automatic finishTest();
    $display("checks=%0d mismatches=%0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until taken, answer captured in its one-cycle window
  task automatic prog(input flk_pcmd_e c, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clock);
    progValid <= 1'b1;
    progReq <= '{cmd: c, addr: a, data: d};
    do begin
      @(negedge clock);
      n++;
    end while (progReady !== 1'b1 && n < 40);
    @(posedge clock);
    progValid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (progRespValid !== 1'b1 && n < 40);
    chk(progRespValid, 1'b1);
    rsp = progResp;
  endtask

  task automatic sw(input logic w, input logic x, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clock);
    swValid <= 1'b1;
    swReq <= '{write: w, extra_array_flash: x, addr: a, data: d};
    do begin
      @(negedge clock);
      n++;
    end while (swReady !== 1'b1 && n < 40);
    @(posedge clock);
    swValid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (swRespValid !== 1'b1 && n < 40);
    chk(swRespValid, 1'b1);
    swData = swRdata;
  endtask

  task automatic tblRead(input logic ext);
    @(posedge clock);
    tblValid <= 1'b1;
    tblFromExt <= ext;
    @(negedge clock);
  endtask

  // shipped configuration, and the pin held once captured
  task automatic tFactory();
    logic e;
    repeat (2) @(negedge clock);
    chk(secLevel, LVL_4);
    chk(bootAddr, BOOT_ADDR_ISP);
    chk(doubleSpeed, 1'b0);
    chk(auxRamEnable, 1'b1);
    chk(extExecAllow, 1'b0);
    chk(bootVectorHigh, SBV_RESET);
    e = eaEffective;
    @(posedge clock);
    eaPin <= !eaPin;
    @(negedge clock);
    chk(eaEffective, e);
  endtask

  // locked part: id open, code port shut, software path open
  task automatic tLocked();
    prog(PCMD_READ_ID, 16'h0000, 8'h00);
    chk({rsp.data, rsp.refused}, {PART_ID_0, 1'b0});
    prog(PCMD_READ_ID, 16'h0001, 8'h00);
    chk({rsp.data, rsp.refused}, {PART_ID_1, 1'b0});
    prog(PCMD_PROG_CODE, 16'h0005, 8'h11);
    chk({rsp.data, rsp.refused}, 9'h001);
    prog(PCMD_VERIFY_CODE, 16'h0005, 8'h00);
    chk({rsp.data, rsp.refused}, 9'h001);
    tblRead(1'b1);
    chk(tblAllow, 1'b0);
    tblRead(1'b0);
    chk(tblAllow, 1'b1);
    sw(1'b1, 1'b0, 16'h0005, 8'ha5);
    sw(1'b0, 1'b0, 16'h0005, 8'h00);
    chk(swData, 8'ha5);
    prog(PCMD_READ_XAF, {12'h000, XAF_SBV_IDX}, 8'h00);
    chk(rsp.data, SBV_RESET);
    prog(PCMD_PROG_XAF, 16'h0003, 8'h42);
    sw(1'b0, 1'b1, 16'h0003, 8'h00);
    chk(swData, 8'h42);
    // software write to the boot vector slot; the mid-run reset restores it
    sw(1'b1, 1'b1, {12'h000, XAF_SBV_IDX}, 8'h37);
    chk(bootVectorHigh, 8'h37);
  endtask

  // each step: optional erase, then security byte bits cleared by an and-write
  task automatic tLevels();
    logic [8:0] steps [6] = '{9'h137, 9'h0fe, 9'h0fd, 9'h0fb, 9'h1fd, 9'h1fb};
    flk_level_e lv [6] = '{LVL_1, LVL_2, LVL_3, LVL_4, LVL_3, LVL_4};
    logic [7:0] hardware_security_byte;
    logic       e;
    hardware_security_byte = HSB_FACTORY;
    for (int i = 0; i < 6; i++) begin
      if (steps[i][8]) begin
        prog(PCMD_CHIP_ERASE, 16'h0000, 8'h00);
        hardware_security_byte = HSB_ERASED;
        prog(PCMD_VERIFY_CODE, 16'h0005, 8'h00);
        chk({rsp.data, rsp.refused}, {8'hff, 1'b0});
      end
      prog(PCMD_PROG_HSB, 16'h0000, steps[i][7:0]);
      hardware_security_byte = (hardware_security_byte & steps[i][7:0]) | HSB_RSVD_MASK;
      prog(PCMD_READ_HSB, 16'h0000, 8'h00);
      chk(rsp.data, hardware_security_byte);
      chk(secLevel, lv[i]);
      chk(bootAddr, hardware_security_byte[6] ? BOOT_ADDR_USER : BOOT_ADDR_ISP);
      chk(doubleSpeed, !hardware_security_byte[7]);
      chk(auxRamEnable, hardware_security_byte[3]);
      chk(extExecAllow, lv[i] != LVL_4);
      tblRead(1'b1);
      chk(tblAllow, lv[i] == LVL_1);
      prog(PCMD_PROG_CODE, 16'h0007, 8'h99);
      chk(rsp.refused, lv[i] != LVL_1);
      prog(PCMD_VERIFY_CODE, 16'h0007, 8'h00);
      chk({rsp.data, rsp.refused}, (lv[i] > LVL_2) ? 9'h001 : 9'h132);
      e = eaEffective;
      @(posedge clock);
      eaPin <= !eaPin;
      @(negedge clock);
      chk(eaEffective, (lv[i] == LVL_1) ? eaPin : e);
    end
  endtask

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // hang guard: whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      nFail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, cycles, 0);
      finishTest();
    end
  end

  initial begin
    arst_n = 1'b0;
    progValid = 1'b0;
    progReq = '0;
    swValid = 1'b0;
    swReq = '0;
    tblValid = 1'b0;
    tblFromExt = 1'b0;
    eaPin = 1'b1;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    tFactory();
    tLocked();
    tLevels();
    // second reset in mid-run brings back the shipped byte
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    tFactory();
    finishTest();
  end
endmodule

bind flk_lock_ctrl flk_lock_ctrl_asserts u_flk_lock_ctrl_asserts (.clock(clock),
  .arst_n(arst_n), .progValid(progValid), .progReq(progReq), .progReady(progReady),
  .progRespValid(progRespValid), .progResp(progResp), .swValid(swValid),
  .swReady(swReady), .swRespValid(swRespValid), .flashEraseAll(flashEraseAll),
  .tblValid(tblValid), .tblFromExt(tblFromExt), .tblAllow(tblAllow),
  .extExecAllow(extExecAllow), .eaEffective(eaEffective), .secLevel(secLevel));
